// ### include/lsr_pkg.sv
// Package of offsets, field layouts and frame constants for the status bank
package lsr_pkg;

   // ==========================================================
   // Serial frame layout
   // ==========================================================
   localparam int LSR_ADDR_W = 13;                   // Register address width
   localparam int LSR_DATA_W = 8;                    // Register data width
   localparam logic [4:0] LSR_INSTR_LAST = 5'h0f;    // Index of last instr bit
   localparam int LSR_RW_POS = 15;                   // Read flag, 1 = read
   localparam logic [3:0] LSR_DATA_BITS = 4'h8;      // Data bits per frame

   // ==========================================================
   // Register offsets
   // ==========================================================
   localparam logic [12:0] LSR_OFS_INPUT_LOOP_STATE = 13'h0082;
   localparam logic [12:0] LSR_OFS_HOLDOVER_AVERAGE_CODE = 13'h0083;
   localparam logic [12:0] LSR_OFS_HOLDOVER_PRESENT_CODE = 13'h0084;
   localparam logic [12:0] LSR_OFS_INPUT_LOOP_REFERENCE_HEALTH = 13'h0085;
   localparam logic [12:0] LSR_OFS_HOLDOVER_EXIT_PHASE = 13'h0086;
   localparam logic [12:0] LSR_OFS_INPUT_LOOP_SPARE = 13'h0087;
   localparam logic [12:0] LSR_OFS_OSCILLATOR_BANK_RESULT = 13'h008c;
   localparam logic [12:0] LSR_OFS_TUNING_ERROR_LOW = 13'h008d;
   localparam logic [12:0] LSR_OFS_TUNING_ERROR_HIGH_FLAGS = 13'h008e;
   localparam logic [12:0] LSR_OFS_TUNE_AND_SYNC_STATES = 13'h008f;
   localparam logic [12:0] LSR_OFS_OUTPUT_LOOP_SPARE = 13'h0090;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int LSR_POS_PREFERRED_REF = 5;    // [6:5]
   localparam int LSR_POS_ACTIVE_REF = 3;       // [4:3]
   localparam int LSR_POS_LOOP_STATE = 0;       // [2:0]
   localparam int LSR_POS_COMPARATOR = 7;       // Present code register
   localparam int LSR_POS_ACTIVE_LOS = 3;       // Health register
   localparam int LSR_POS_REF_FASTER = 2;
   localparam int LSR_POS_ADC_MOVING = 1;
   localparam int LSR_POS_RANGE_OUT = 0;
   localparam int LSR_POS_EXIT_PHASE = 3;       // [4:3]
   localparam int LSR_POS_TUNE_BUSY = 7;
   localparam int LSR_POS_ERROR_SIGN = 6;
   localparam int LSR_POS_AUTOTUNE_STATE = 4;   // [7:4]
   localparam int LSR_POS_SYNC_STATE = 0;       // [3:0]

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [7:0] LSR_RESET_BYTE = 8'h00;  // All status bytes
   localparam logic [7:0] LSR_READ_ZERO = 8'h00;   // Reserved reads

   // ==========================================================
   // Field encodings
   // ==========================================================
   localparam logic [2:0] LSR_LOOP_RESET = 3'h0;
   localparam logic [2:0] LSR_LOOP_ACQUIRE = 3'h1;
   localparam logic [2:0] LSR_LOOP_LOCKED = 3'h2;
   localparam logic [2:0] LSR_LOOP_INVALID = 3'h3;
   localparam logic [2:0] LSR_LOOP_HOLDOVER = 3'h4;
   localparam logic [2:0] LSR_LOOP_ASSISTED_EXIT = 3'h5;
   localparam logic [3:0] LSR_TUNE_IDLE = 4'h0;
   localparam logic [3:0] LSR_TUNE_MEASURE = 4'h6;
   localparam logic [3:0] LSR_TUNE_UPDATE = 4'h9;
   localparam logic [3:0] LSR_TUNE_ROUND = 4'ha;
   localparam logic [3:0] LSR_TUNE_FINISH = 4'hb;
   localparam int LSR_TUNE_UPDATE_PASSES = 18;
   localparam logic [3:0] LSR_SYNC_IDLE = 4'h0;
   localparam logic [3:0] LSR_SYNC_UP_A = 4'h4;
   localparam logic [3:0] LSR_SYNC_UP_B = 4'h6;
   localparam logic [3:0] LSR_SYNC_SEND = 4'h7;
   localparam logic [3:0] LSR_SYNC_DOWN_A = 4'he;
   localparam logic [3:0] LSR_SYNC_DOWN_B = 4'hc;

   // Serial port sequencer states
   typedef enum logic [1:0] {
      LSR_IDLE,
      LSR_INSTR,
      LSR_READ,
      LSR_DONE
   } lsr_port_state_t;

endpackage

// ### hw/lsr_edge_finder.sv
// Edge finder for a group of synchronous levels
`timescale 1ns/1ns
module lsr_edge_finder #(
   parameter int WIDTH = 1
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise,
   output logic [WIDTH-1:0] fall
);

   // ==========================================================
   // Previous level
   // ==========================================================
   logic [WIDTH-1:0] prev;       // Level one cycle ago
   logic [WIDTH-1:0] next_prev;  // Next value of prev

   // Track the level
   always_comb begin
      next_prev = level;
   end

   // Register the level, zero at reset
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prev <= '0;
      end else begin
         prev <= next_prev;
      end
   end

   // Edges are one-cycle pulses aligned with the new level
   assign rise = level & ~prev;
   assign fall = ~level & prev;

endmodule

// ### hw/lsr_tune_capture.sv
// Holder of the oscillator bank chosen by the last autotune run
`timescale 1ns/1ns
module lsr_tune_capture
   import lsr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic tune_done,
   input wire logic [7:0] bank_select,
   output logic [7:0] bank_result
);

   // ==========================================================
   // Result register
   // ==========================================================
   logic [7:0] next_bank_result;  // Next held bank

   // Load the bank only when a run finishes
   always_comb begin
      next_bank_result = bank_result;
      if (tune_done) begin
         next_bank_result = bank_select;
      end
   end

   // Register the result
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         bank_result <= LSR_RESET_BYTE;
      end else begin
         bank_result <= next_bank_result;
      end
   end

endmodule

// ### hw/lsr_loop_status.sv
// Status readback bank for the input and output loops, serial port access
`timescale 1ns/1ns
module lsr_loop_status
   import lsr_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   // Serial control port
   input wire logic port_select_n,
   input wire logic port_clock,
   input wire logic port_data_in,
   output logic port_data_out,
   output logic port_data_oe,
   // Input loop status sources
   input wire logic [2:0] input_loop_state_field,
   input wire logic [1:0] preferred_reference,
   input wire logic [1:0] active_reference_input,
   input wire logic [6:0] average_code,
   input wire logic [6:0] present_code,
   input wire logic holdover_comparator,
   input wire logic [3:0] reference_input_los,
   input wire logic [3:0] reference_input_enable,
   input wire logic [3:0] reference_input_faster,
   input wire logic converter_moving,
   input wire logic tuning_voltage_out_of_range,
   input wire logic [1:0] holdover_exit_phase_field,
   // Output loop status sources
   input wire logic [7:0] oscillator_bank_select,
   input wire logic [13:0] tuning_error_count,
   input wire logic tuning_error_negative,
   input wire logic autotune_busy,
   input wire logic [3:0] autotune_state_field,
   input wire logic [3:0] sync_state_field
);

   // ==========================================================
   // Edge detection of port clock and autotune busy
   // ==========================================================
   logic [1:0] edge_level;  // Busy, port clock, both idle low
   logic [1:0] edge_rise;   // Rising edge pulses
   logic [1:0] edge_fall;   // Falling edge pulses
   logic clock_rise;        // Port clock rising edge
   logic clock_fall;        // Port clock falling edge
   logic tune_done;         // Autotune run has ended

   assign edge_level = {autotune_busy, port_clock};
   assign clock_rise = edge_rise[0];
   assign clock_fall = edge_fall[0];
   assign tune_done = edge_fall[1];

   // Zero reset matches idle low levels, so no false edge after reset
   lsr_edge_finder #(
      .WIDTH(2)
   ) u_lsr_edge_finder (
      .clock(clock),
      .reset_n(reset_n),
      .level(edge_level),
      .rise(edge_rise),
      .fall(edge_fall)
   );

   // ==========================================================
   // Autotune bank result
   // ==========================================================
   logic [7:0] bank_result;  // Bank held since the last run

   // Captured when busy drops at the end of a run
   lsr_tune_capture u_lsr_tune_capture (
      .clock(clock),
      .reset_n(reset_n),
      .tune_done(tune_done),
      .bank_select(oscillator_bank_select),
      .bank_result(bank_result)
   );

   // ==========================================================
   // Live status snapshot
   // ==========================================================
   logic [7:0] loop_state_byte;      // Input loop state register
   logic [7:0] average_byte;         // Averaged code register
   logic [7:0] present_byte;         // Present code register
   logic [7:0] health_byte;          // Reference health register
   logic [7:0] exit_byte;            // Exit phase register
   logic [7:0] error_low_byte;       // Tuning error low register
   logic [7:0] error_high_byte;      // Tuning error high and flags
   logic [7:0] states_byte;          // Autotune and sync states
   logic [7:0] next_loop_state_byte;
   logic [7:0] next_average_byte;
   logic [7:0] next_present_byte;
   logic [7:0] next_health_byte;
   logic [7:0] next_exit_byte;
   logic [7:0] next_error_low_byte;
   logic [7:0] next_error_high_byte;
   logic [7:0] next_states_byte;
   logic active_los;                 // Loss on the reference in use
   logic any_faster;                 // An enabled reference runs fast

   // Pack the sources into register images, reserved bits zero
   always_comb begin
      active_los = reference_input_los[active_reference_input];
      any_faster = |(reference_input_faster &
                     reference_input_enable);
      next_loop_state_byte = LSR_READ_ZERO;
      next_loop_state_byte[LSR_POS_LOOP_STATE +: 3] =
         input_loop_state_field;
      next_loop_state_byte[LSR_POS_PREFERRED_REF +: 2] =
         preferred_reference;
      next_loop_state_byte[LSR_POS_ACTIVE_REF +: 2] =
         active_reference_input;
      next_average_byte = {1'b0, average_code};
      next_present_byte = {1'b0, present_code};
      next_present_byte[LSR_POS_COMPARATOR] = holdover_comparator;
      next_health_byte = LSR_READ_ZERO;
      next_health_byte[LSR_POS_ACTIVE_LOS] = active_los;
      next_health_byte[LSR_POS_REF_FASTER] = any_faster;
      next_health_byte[LSR_POS_ADC_MOVING] = converter_moving;
      next_health_byte[LSR_POS_RANGE_OUT] =
         tuning_voltage_out_of_range;
      next_exit_byte = LSR_READ_ZERO;
      next_exit_byte[LSR_POS_EXIT_PHASE +: 2] =
         holdover_exit_phase_field;
      next_error_low_byte = tuning_error_count[7:0];
      next_error_high_byte = {2'b00, tuning_error_count[13:8]};
      next_error_high_byte[LSR_POS_TUNE_BUSY] = autotune_busy;
      next_error_high_byte[LSR_POS_ERROR_SIGN] =
         tuning_error_negative;
      next_states_byte = LSR_READ_ZERO;
      next_states_byte[LSR_POS_AUTOTUNE_STATE +: 4] =
         autotune_state_field;
      next_states_byte[LSR_POS_SYNC_STATE +: 4] = sync_state_field;
   end

   // Refresh the snapshot every cycle so reads see live status
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         loop_state_byte <= LSR_RESET_BYTE;
         average_byte <= LSR_RESET_BYTE;
         present_byte <= LSR_RESET_BYTE;
         health_byte <= LSR_RESET_BYTE;
         exit_byte <= LSR_RESET_BYTE;
         error_low_byte <= LSR_RESET_BYTE;
         error_high_byte <= LSR_RESET_BYTE;
         states_byte <= LSR_RESET_BYTE;
      end else begin
         loop_state_byte <= next_loop_state_byte;
         average_byte <= next_average_byte;
         present_byte <= next_present_byte;
         health_byte <= next_health_byte;
         exit_byte <= next_exit_byte;
         error_low_byte <= next_error_low_byte;
         error_high_byte <= next_error_high_byte;
         states_byte <= next_states_byte;
      end
   end

   // ==========================================================
   // Address decode for reads
   // ==========================================================
   logic [15:0] instr_word;     // Instruction with the newest bit
   logic [12:0] read_address;   // Address of the frame
   logic [7:0] read_byte;       // Value selected for that address

   // Choose the register image, zero for unmapped and spare offsets
   always_comb begin
      read_address = instr_word[LSR_ADDR_W-1:0];
      unique case (read_address)
         LSR_OFS_INPUT_LOOP_STATE: begin
            read_byte = loop_state_byte;
         end
         LSR_OFS_HOLDOVER_AVERAGE_CODE: begin
            read_byte = average_byte;
         end
         LSR_OFS_HOLDOVER_PRESENT_CODE: begin
            read_byte = present_byte;
         end
         LSR_OFS_INPUT_LOOP_REFERENCE_HEALTH: begin
            read_byte = health_byte;
         end
         LSR_OFS_HOLDOVER_EXIT_PHASE: begin
            read_byte = exit_byte;
         end
         LSR_OFS_OSCILLATOR_BANK_RESULT: begin
            read_byte = bank_result;
         end
         LSR_OFS_TUNING_ERROR_LOW: begin
            read_byte = error_low_byte;
         end
         LSR_OFS_TUNING_ERROR_HIGH_FLAGS: begin
            read_byte = error_high_byte;
         end
         LSR_OFS_TUNE_AND_SYNC_STATES: begin
            read_byte = states_byte;
         end
         default: begin
            read_byte = LSR_READ_ZERO;
         end
      endcase
   end

   // ==========================================================
   // Serial port sequencer
   // ==========================================================
   lsr_port_state_t port_state;       // Frame phase
   lsr_port_state_t next_port_state;
   logic [4:0] bit_count;             // Instruction bits taken
   logic [4:0] next_bit_count;
   logic [15:0] instr_shift;          // Instruction bits so far
   logic [15:0] next_instr_shift;
   logic [7:0] out_shift;             // Read data still to send
   logic [7:0] next_out_shift;
   logic [3:0] out_left;              // Read bits still to send
   logic [3:0] next_out_left;
   logic next_port_data_out;
   logic next_port_data_oe;

   assign instr_word = {instr_shift[14:0], port_data_in};

   // Sample on port clock rise, drive read data on port clock fall
   always_comb begin
      next_port_state = port_state;
      next_bit_count = bit_count;
      next_instr_shift = instr_shift;
      next_out_shift = out_shift;
      next_out_left = out_left;
      next_port_data_out = port_data_out;
      next_port_data_oe = port_data_oe;
      if (port_select_n) begin
         // Deselect ends any frame and frees the data pin
         next_port_state = LSR_IDLE;
         next_bit_count = 5'h00;
         next_port_data_oe = 1'b0;
         next_port_data_out = 1'b0;
      end else begin
         unique case (port_state)
            LSR_IDLE: begin
               // Selection opens a new frame
               next_port_state = LSR_INSTR;
               next_bit_count = 5'h00;
            end
            LSR_INSTR: begin
               // Gather read flag and address
               if (clock_rise) begin
                  next_instr_shift = instr_word;
                  next_bit_count = bit_count + 5'h01;
                  if (bit_count == LSR_INSTR_LAST) begin
                     if (instr_word[LSR_RW_POS]) begin
                        next_out_shift = read_byte;
                        next_out_left = LSR_DATA_BITS;
                        next_port_state = LSR_READ;
                     end else begin
                        next_port_state = LSR_DONE;
                     end
                  end
               end
            end
            LSR_READ: begin
               // Shift out most significant bit first
               if (clock_fall) begin
                  if (out_left != 4'h0) begin
                     next_port_data_oe = 1'b1;
                     next_port_data_out = out_shift[7];
                     next_out_shift = {out_shift[6:0], 1'b0};
                     next_out_left = out_left - 4'h1;
                  end else begin
                     next_port_data_oe = 1'b0;
                     next_port_data_out = 1'b0;
                     next_port_state = LSR_DONE;
                  end
               end
            end
            LSR_DONE: begin
               // Remaining bits, including write data, are ignored
               next_port_state = LSR_DONE;
            end
         endcase
      end
   end

   // Register the sequencer and the pin drivers
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         port_state <= LSR_IDLE;
         bit_count <= 5'h00;
         instr_shift <= 16'h0000;
         out_shift <= LSR_RESET_BYTE;
         out_left <= 4'h0;
         port_data_out <= 1'b0;
         port_data_oe <= 1'b0;
      end else begin
         port_state <= next_port_state;
         bit_count <= next_bit_count;
         instr_shift <= next_instr_shift;
         out_shift <= next_out_shift;
         out_left <= next_out_left;
         port_data_out <= next_port_data_out;
         port_data_oe <= next_port_data_oe;
      end
   end

endmodule

// ### testbench/lsr_loop_status_checker.sv
// Checker of serial port timing for the loop status bank
`timescale 1ns/1ns
module lsr_loop_status_checker (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic port_select_n,
   input wire logic port_clock,
   input wire logic port_data_in,
   input wire logic port_data_out,
   input wire logic port_data_oe
);
   // ==========================================
   // Frame tracking
   // ==========================================
   logic [4:0] rise_cnt; // Port clock rises in frame
   logic [4:0] next_rise_cnt;
   logic read_bit; // First instruction bit
   logic next_read_bit;
   logic last_pclk; // Port clock one cycle ago
   // Count rises while selected, catch the read flag
   always_comb begin
      next_rise_cnt = rise_cnt;
      next_read_bit = read_bit;
      if (port_select_n) begin
         next_rise_cnt = 5'h00;
         next_read_bit = 1'b0;
      end else if (port_clock && !last_pclk && rise_cnt != 5'h1f) begin
         next_rise_cnt = rise_cnt + 5'h01;
         if (rise_cnt == 5'h00) begin
            next_read_bit = port_data_in;
         end
      end
   end
   // Register the tracking state
   always_ff @(posedge clock) begin
      last_pclk <= port_clock;
      if (!reset_n) begin
         rise_cnt <= 5'h00;
         read_bit <= 1'b0;
      end else begin
         rise_cnt <= next_rise_cnt;
         read_bit <= next_read_bit;
      end
   end
   // ==========================================
   // Assertions
   // ==========================================
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Data pin held for at least eight clock cycles once driven
   sequence data_run_s;
      port_data_oe [*8];
   endsequence
   reset_quiet_a: assert property ($rose(reset_n) |-> !port_data_oe)
      else $error("Data pin driven at reset release");
   deselect_quiet_a: assert property (port_select_n |=> !port_data_oe)
      else $error("Data pin driven while deselected");
   idle_low_a: assert property (!port_data_oe |-> !port_data_out)
      else $error("Data out high while pin released");
   oe_start_a: assert property ($rose(port_data_oe) |->
      rise_cnt == 5'h10 && read_bit)
      else $error("Data pin driven outside a read");
   oe_sync_a: assert property ($rose(port_data_oe) |->
      $past(port_clock, 2) && !$past(port_clock))
      else $error("Data pin not driven after a clock fall");
   data_hold_a: assert property (!port_select_n && !$fell(port_clock)
      |=> $stable(port_data_out))
      else $error("Data out changed without a clock fall");
   oe_end_a: assert property ($fell(port_data_oe) && !port_select_n
      |-> rise_cnt == 5'h18)
      else $error("Data phase length wrong");
   oe_stand_a: assert property ($rose(port_data_oe) |-> data_run_s)
      else $error("Data pin released too early");
endmodule
bind lsr_loop_status lsr_loop_status_checker u_lsr_loop_status_checker (
   .clock(clock), .reset_n(reset_n), .port_select_n(port_select_n),
   .port_clock(port_clock), .port_data_in(port_data_in),
   .port_data_out(port_data_out), .port_data_oe(port_data_oe));

// ### testbench/lsr_loop_status_tb.sv
// Self-checking bench for the loop status bank
`timescale 1ns/1ns
module lsr_loop_status_tb;
   import lsr_pkg::*;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic port_select_n = 1'b1, port_clock = 1'b0, port_data_in = 1'b0;
   logic port_data_out, port_data_oe;
   logic [2:0] loop_st = 3'h0;
   logic [1:0] pref = 2'h0, act = 2'h0, phase = 2'h0;
   logic [6:0] avg = 7'h00, pres = 7'h00;
   logic cmp = 1'b0, moving = 1'b0, range_out = 1'b0;
   logic [3:0] los = 4'h0, ena = 4'h0, faster = 4'h0;
   logic [7:0] bank = 8'h00;
   logic [13:0] err = 14'h0000;
   logic neg = 1'b0, busy = 1'b0;
   logic [3:0] tune_st = 4'h0, sync_st = 4'h0;
   int errors = 0, total_checks = 0, cycles = 0;
   always #25 clock = ~clock;
   lsr_loop_status u_lsr_loop_status (
      .clock(clock), .reset_n(reset_n), .port_select_n(port_select_n),
      .port_clock(port_clock), .port_data_in(port_data_in),
      .port_data_out(port_data_out), .port_data_oe(port_data_oe),
      .input_loop_state_field(loop_st), .preferred_reference(pref),
      .active_reference_input(act), .average_code(avg),
      .present_code(pres), .holdover_comparator(cmp),
      .reference_input_los(los), .reference_input_enable(ena),
      .reference_input_faster(faster), .converter_moving(moving),
      .tuning_voltage_out_of_range(range_out),
      .holdover_exit_phase_field(phase), .oscillator_bank_select(bank),
      .tuning_error_count(err), .tuning_error_negative(neg),
      .autotune_busy(busy), .autotune_state_field(tune_st),
      .sync_state_field(sync_st));
   // ==========================================
   // Shared tasks
   // ==========================================
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One frame: sixteen instruction bits then eight data bits
   task automatic frame(input logic rd, input logic [12:0] addr,
      output logic [7:0] data, output logic oe_seen);
      logic [15:0] instr;
      instr = {rd, 2'b00, addr};
      data = 8'h00;
      oe_seen = 1'b0;
      port_select_n = 1'b0;
      for (int i = 0; i < 24; i++) begin
         port_clock = 1'b0;
         port_data_in = (i < 16) ? instr[15 - i] : 1'b0;
         step(4);
         if (i >= 16) begin
            data = {data[6:0], port_data_out};
            oe_seen = oe_seen | port_data_oe;
         end
         port_clock = 1'b1;
         step(4);
      end
      port_clock = 1'b0;
      step(4);
      port_select_n = 1'b1;
      step(2);
   endtask
   task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      logic oe;
      step(2);
      frame(1'b1, addr, d, oe);
      check(d, exp);
      check({7'h00, oe}, 8'h01);
   endtask
   // ==========================================
   // Scenarios
   // ==========================================
   task automatic output_task();
      bank = 8'h3c;
      busy = 1'b1;
      err = 14'h2a5b;
      neg = 1'b1;
      rd_chk(LSR_OFS_OSCILLATOR_BANK_RESULT, 8'h00);
      rd_chk(LSR_OFS_TUNING_ERROR_LOW, 8'h5b);
      rd_chk(LSR_OFS_TUNING_ERROR_HIGH_FLAGS, 8'hea);
      busy = 1'b0;
      step(2);
      bank = 8'hc3;
      err = 14'h1f00;
      neg = 1'b0;
      rd_chk(LSR_OFS_OSCILLATOR_BANK_RESULT, 8'h3c);
      rd_chk(LSR_OFS_TUNING_ERROR_HIGH_FLAGS, 8'h1f);
   endtask
   task automatic input_loop_task();
      for (int s = 0; s < 6; s++) begin
         loop_st = 3'(s);
         pref = 2'(s);
         act = 2'(5 - s);
         rd_chk(LSR_OFS_INPUT_LOOP_STATE,
            {1'b0, pref, act, loop_st});
      end
   endtask
   task automatic codes_task();
      avg = 7'h55;
      pres = 7'h2a;
      cmp = 1'b1;
      rd_chk(LSR_OFS_HOLDOVER_AVERAGE_CODE, 8'h55);
      rd_chk(LSR_OFS_HOLDOVER_PRESENT_CODE, 8'haa);
      avg = 7'h7f;
      cmp = 1'b0;
      rd_chk(LSR_OFS_HOLDOVER_AVERAGE_CODE, 8'h7f);
      rd_chk(LSR_OFS_HOLDOVER_PRESENT_CODE, 8'h2a);
   endtask
   task automatic health_task();
      act = 2'h2;
      los = 4'h4;
      ena = 4'h1;
      faster = 4'h2;
      moving = 1'b1;
      rd_chk(LSR_OFS_INPUT_LOOP_REFERENCE_HEALTH, 8'h0a);
      los = 4'hb;
      ena = 4'h2;
      moving = 1'b0;
      range_out = 1'b1;
      rd_chk(LSR_OFS_INPUT_LOOP_REFERENCE_HEALTH, 8'h05);
      phase = 2'h3;
      rd_chk(LSR_OFS_HOLDOVER_EXIT_PHASE, 8'h18);
      phase = 2'h1;
      rd_chk(LSR_OFS_HOLDOVER_EXIT_PHASE, 8'h08);
   endtask
   task automatic states_task();
      logic [3:0] codes [6];
      codes = '{LSR_SYNC_IDLE, LSR_SYNC_UP_A, LSR_SYNC_UP_B, LSR_SYNC_SEND,
         LSR_SYNC_DOWN_A, LSR_SYNC_DOWN_B};
      for (int a = 0; a < 12; a++) begin
         tune_st = 4'(a);
         sync_st = codes[a % 6];
         rd_chk(LSR_OFS_TUNE_AND_SYNC_STATES, {tune_st, sync_st});
      end
   endtask
   task automatic refused_task();
      logic [7:0] d;
      logic oe;
      step(2);
      frame(1'b0, LSR_OFS_INPUT_LOOP_STATE, d, oe);
      check({7'h00, oe}, 8'h00);
      check(d, 8'h00);
      rd_chk(LSR_OFS_INPUT_LOOP_STATE, {1'b0, pref, act, loop_st});
      rd_chk(LSR_OFS_INPUT_LOOP_SPARE, 8'h00);
      rd_chk(LSR_OFS_OUTPUT_LOOP_SPARE, 8'h00);
      rd_chk(13'h1fff, 8'h00);
   endtask
   task automatic summarize();
      if (errors == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      step(20);
      check({7'h00, port_data_oe}, 8'h00);
      reset_n = 1'b1;
      step(2);
      output_task();
      input_loop_task();
      codes_task();
      health_task();
      states_task();
      refused_task();
      summarize();
   end
endmodule
